// >>> rtl/msp_cfg.svh
`ifndef MSP_CFG_SVH
`define MSP_CFG_SVH
// serial word and command layout
`define MSP_BYTE_W 8
`define MSP_LAST_BIT 3'h7
`define MSP_FIRST_BIT 3'h0
`define MSP_CMD_WR_BIT 7
`define MSP_ADDR_W 4
`define MSP_ADDR_MSB 3
`define MSP_DEPTH 16
// byte positions inside a frame
`define MSP_BYTE_CMD 2'h0
`define MSP_BYTE_TURN 2'h1
`define MSP_BYTE_DATA 2'h2
// serial addresses of the event registers
`define MSP_ADDR_STATUS 4'h0
`define MSP_ADDR_MASK 4'h1
// event sources
`define MSP_SRC_W 3
`define MSP_SRC_ACT 0
`define MSP_SRC_APP 1
`define MSP_SRC_WAVE 2
`define MSP_SRC_NONE 3'h0
`define MSP_BYTE_ZERO 8'h00
`define MSP_ADDR_ZERO 4'h0
`endif

// >>> rtl/msp_pkg.sv
`include "msp_cfg.svh"
package msp_pkg;
  // position of the link inside its frame
  typedef enum logic [1:0] {
    MSP_PH_CMD = 2'b00,
    MSP_PH_TURN = 2'b01,
    MSP_PH_DATA = 2'b10
  } msp_phase_type;
  // core side read fetch sequence
  typedef enum logic [1:0] {
    MSP_C_IDLE = 2'b00,
    MSP_C_FETCH = 2'b01
  } msp_core_state_type;
  // one request handed from the link to the core
  typedef struct packed {
    logic wr;
    logic [`MSP_ADDR_W-1:0] addr;
    logic [`MSP_BYTE_W-1:0] data;
  } msp_req_type;
endpackage : msp_pkg

// >>> rtl/msp_reg_mem.sv
`timescale 1ns/1ps
`default_nettype none
`include "msp_cfg.svh"
module msp_reg_mem
  import msp_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // write port
  input wire logic we_i,
  input wire logic [`MSP_ADDR_W-1:0] waddr_i,
  input wire logic [`MSP_BYTE_W-1:0] wdata_i,
  // read port, data one cycle after address
  input wire logic [`MSP_ADDR_W-1:0] raddr_i,
  output logic [`MSP_BYTE_W-1:0] rdata_o
);
  logic [`MSP_BYTE_W-1:0] mem_ff [`MSP_DEPTH]; // storage words
  logic [`MSP_BYTE_W-1:0] rdata_ff; // registered read data

  // storage write, no reset on the array
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_ff[waddr_i] <= wdata_i;
    end
  end

  // registered read
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff <= `MSP_BYTE_ZERO;
    end else begin
      rdata_ff <= mem_ff[raddr_i];
    end
  end

  assign rdata_o = rdata_ff;
endmodule : msp_reg_mem
`default_nettype wire

// >>> rtl/msp_serial_port.sv
// Notes on behaviour
// - reset low holds all logic but the register array, serial port reset
// - interrupt pin active low, open drain
// - maskable active, apparent, waveform event sources
// - chip select low; respond only while selected
// - input data captured on falling clock edge
// - output data launched on rising clock edge
// - data output high impedance unless driving data
`timescale 1ns/1ps
`default_nettype none
`include "msp_cfg.svh"
module msp_serial_port
  import msp_pkg::*;
(
  // core clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // serial link from the host
  input wire logic link_sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  // serial data output pin, two signals
  output logic miso_o,
  output logic miso_oe_n_o,
  // interrupt pin, open drain
  output logic irq_o,
  output logic irq_oe_n_o,
  // event sources from the metering core, one-cycle pulses
  input wire logic act_half_i,
  input wire logic app_half_i,
  input wire logic wave_rdy_i
);

  // ---------------- link domain ----------------
  logic link_rst_n; // frame-scoped reset: device reset or deselect
  logic [2:0] fbit_ff; // falling edge bit counter
  logic [2:0] nxt_fbit;
  logic [`MSP_BYTE_W-2:0] rx_sh_ff; // input shift register
  logic [`MSP_BYTE_W-2:0] nxt_rx_sh;
  msp_phase_type fph_ff; // falling edge frame phase
  msp_phase_type nxt_fph;
  logic [`MSP_BYTE_W-1:0] cmd_ff; // command byte of this frame
  logic [`MSP_BYTE_W-1:0] nxt_cmd;
  logic [`MSP_BYTE_W-1:0] rx_byte; // byte completing this edge
  logic req_tgl_ff; // request toggle to the core
  logic nxt_req_tgl;
  msp_req_type req_ff; // request word held for the core
  msp_req_type nxt_req;
  logic [2:0] rbit_ff; // rising edge bit counter
  logic [2:0] nxt_rbit;
  msp_phase_type rph_ff; // rising edge frame phase
  msp_phase_type nxt_rph;
  logic [`MSP_BYTE_W-1:0] tx_sh_ff; // output shift register
  logic [`MSP_BYTE_W-1:0] nxt_tx_sh;
  logic miso_ff; // data pin level
  logic nxt_miso;
  logic miso_oe_n_ff; // data pin enable, low drives
  logic nxt_miso_oe_n;

  // ---------------- core domain ----------------
  logic tgl_s1_ff; // synchroniser first stage
  logic tgl_s2_ff; // synchroniser second stage
  logic tgl_s3_ff; // previous value for edge detection
  logic req_pulse; // one pulse per request
  msp_core_state_type cst_ff; // read fetch state
  msp_core_state_type nxt_cst;
  logic [`MSP_SRC_W-1:0] status_ff; // sticky event flags
  logic [`MSP_SRC_W-1:0] nxt_status;
  logic [`MSP_SRC_W-1:0] mask_ff; // event enables
  logic [`MSP_SRC_W-1:0] nxt_mask;
  logic [`MSP_SRC_W-1:0] src_evt; // this cycle's events
  logic [`MSP_SRC_W-1:0] clr_bits; // bits cleared by a write
  logic [`MSP_BYTE_W-1:0] rdata_ff; // read word held for the link
  logic [`MSP_BYTE_W-1:0] nxt_rdata;
  logic irq_oe_n_ff; // interrupt pin enable, low pulls
  logic nxt_irq_oe_n;
  logic irq_lvl_ff; // interrupt pin data, always low
  logic mem_we; // general register write
  logic [`MSP_BYTE_W-1:0] mem_rdata; // general register read data

  // true for the two addresses that hold event state
  function automatic logic is_event_addr(input logic [`MSP_ADDR_W-1:0] a);
    is_event_addr = (a == `MSP_ADDR_STATUS) || (a == `MSP_ADDR_MASK);
  endfunction : is_event_addr

  // deselect or device reset clears all frame state at once
  assign link_rst_n = rst_n_i & ~cs_n_i;
  assign rx_byte = {rx_sh_ff, mosi_i};

  // falling edge: bit count, shift in, frame phase, command
  always_comb begin
    nxt_fbit = fbit_ff + 3'h1;
    nxt_rx_sh = rx_byte[`MSP_BYTE_W-2:0];
    nxt_fph = fph_ff;
    nxt_cmd = cmd_ff;
    if (fbit_ff == `MSP_LAST_BIT) begin
      // byte boundary: advance the phase
      case (fph_ff)
        MSP_PH_CMD: begin
          nxt_cmd = rx_byte;
          nxt_fph = rx_byte[`MSP_CMD_WR_BIT] ? MSP_PH_DATA : MSP_PH_TURN;
        end
        MSP_PH_TURN: begin
          nxt_fph = MSP_PH_DATA;
        end
        default: begin
          nxt_fph = MSP_PH_DATA;
        end
      endcase
    end
  end

  // falling edge registers, cleared by each deselect
  always_ff @(negedge link_sclk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      fbit_ff <= `MSP_FIRST_BIT;
      rx_sh_ff <= '0;
      fph_ff <= MSP_PH_CMD;
      cmd_ff <= `MSP_BYTE_ZERO;
    end else begin
      fbit_ff <= nxt_fbit;
      rx_sh_ff <= nxt_rx_sh;
      fph_ff <= nxt_fph;
      cmd_ff <= nxt_cmd;
    end
  end

  // request hand-off: a read asks after the command byte, a write after each data byte
  always_comb begin
    nxt_req_tgl = req_tgl_ff;
    nxt_req = req_ff;
    if (fbit_ff == `MSP_LAST_BIT) begin
      if (fph_ff == MSP_PH_CMD && !rx_byte[`MSP_CMD_WR_BIT]) begin
        // read: fetch during the turnaround byte
        nxt_req.wr = 1'b0;
        nxt_req.addr = rx_byte[`MSP_ADDR_MSB:0];
        nxt_req.data = `MSP_BYTE_ZERO;
        nxt_req_tgl = ~req_tgl_ff;
      end else if (fph_ff == MSP_PH_DATA && cmd_ff[`MSP_CMD_WR_BIT]) begin
        // write: every data byte goes to the command's address
        nxt_req.wr = 1'b1;
        nxt_req.addr = cmd_ff[`MSP_ADDR_MSB:0];
        nxt_req.data = rx_byte;
        nxt_req_tgl = ~req_tgl_ff;
      end
    end
  end

  // request registers survive deselect so the toggle stays in step
  always_ff @(negedge link_sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_tgl_ff <= 1'b0;
      req_ff <= '0;
    end else begin
      req_tgl_ff <= nxt_req_tgl;
      req_ff <= nxt_req;
    end
  end

  // rising edge: launch read data, drive the pin only in a read's data bytes
  always_comb begin
    nxt_rbit = rbit_ff + 3'h1;
    nxt_rph = rph_ff;
    nxt_tx_sh = {tx_sh_ff[`MSP_BYTE_W-2:0], 1'b0};
    nxt_miso = tx_sh_ff[`MSP_BYTE_W-1];
    nxt_miso_oe_n = 1'b1;
    if (rbit_ff == `MSP_LAST_BIT) begin
      // phase seen by the next rising edge
      case (rph_ff)
        MSP_PH_CMD: begin
          nxt_rph = MSP_PH_TURN;
        end
        default: begin
          nxt_rph = MSP_PH_DATA;
        end
      endcase
    end
    if (rph_ff == MSP_PH_DATA && !cmd_ff[`MSP_CMD_WR_BIT]) begin
      nxt_miso_oe_n = 1'b0;
      if (rbit_ff == `MSP_FIRST_BIT) begin
        // the core's word has been stable since the turnaround byte
        nxt_miso = rdata_ff[`MSP_BYTE_W-1];
        nxt_tx_sh = {rdata_ff[`MSP_BYTE_W-2:0], 1'b0};
      end
    end
  end

  // rising edge registers, pin released at once on deselect
  always_ff @(posedge link_sclk_i or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rbit_ff <= `MSP_FIRST_BIT;
      rph_ff <= MSP_PH_CMD;
      tx_sh_ff <= `MSP_BYTE_ZERO;
      miso_ff <= 1'b0;
      miso_oe_n_ff <= 1'b1;
    end else begin
      rbit_ff <= nxt_rbit;
      rph_ff <= nxt_rph;
      tx_sh_ff <= nxt_tx_sh;
      miso_ff <= nxt_miso;
      miso_oe_n_ff <= nxt_miso_oe_n;
    end
  end

  // request toggle into the core clock: two flops, then edge detect
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tgl_s1_ff <= 1'b0;
      tgl_s2_ff <= 1'b0;
      tgl_s3_ff <= 1'b0;
    end else begin
      tgl_s1_ff <= req_tgl_ff;
      tgl_s2_ff <= tgl_s1_ff;
      tgl_s3_ff <= tgl_s2_ff;
    end
  end

  assign req_pulse = tgl_s2_ff ^ tgl_s3_ff;
  // general registers take every write outside the event addresses
  assign mem_we = req_pulse && req_ff.wr && !is_event_addr(req_ff.addr);

  // event sources gathered by position
  always_comb begin
    src_evt = `MSP_SRC_NONE;
    src_evt[`MSP_SRC_ACT] = act_half_i;
    src_evt[`MSP_SRC_APP] = app_half_i;
    src_evt[`MSP_SRC_WAVE] = wave_rdy_i;
  end

  // status, mask and interrupt pin; a new event wins over its clear
  always_comb begin
    clr_bits = `MSP_SRC_NONE;
    nxt_mask = mask_ff;
    if (req_pulse && req_ff.wr && req_ff.addr == `MSP_ADDR_STATUS) begin
      clr_bits = req_ff.data[`MSP_SRC_W-1:0];
    end
    if (req_pulse && req_ff.wr && req_ff.addr == `MSP_ADDR_MASK) begin
      nxt_mask = req_ff.data[`MSP_SRC_W-1:0];
    end
    nxt_status = (status_ff & ~clr_bits) | src_evt;
    nxt_irq_oe_n = ~|(status_ff & mask_ff);
  end

  // read fetch: memory answers one cycle after the request
  always_comb begin
    nxt_cst = cst_ff;
    nxt_rdata = rdata_ff;
    case (cst_ff)
      MSP_C_IDLE: begin
        if (req_pulse && !req_ff.wr) begin
          nxt_cst = MSP_C_FETCH;
        end
      end
      MSP_C_FETCH: begin
        // pick event state or general register
        if (req_ff.addr == `MSP_ADDR_STATUS) begin
          nxt_rdata = {{(`MSP_BYTE_W-`MSP_SRC_W){1'b0}}, status_ff};
        end else if (req_ff.addr == `MSP_ADDR_MASK) begin
          nxt_rdata = {{(`MSP_BYTE_W-`MSP_SRC_W){1'b0}}, mask_ff};
        end else begin
          nxt_rdata = mem_rdata;
        end
        nxt_cst = MSP_C_IDLE;
      end
      default: begin
        nxt_cst = MSP_C_IDLE;
      end
    endcase
  end

  // core domain registers
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cst_ff <= MSP_C_IDLE;
      status_ff <= `MSP_SRC_NONE;
      mask_ff <= `MSP_SRC_NONE;
      rdata_ff <= `MSP_BYTE_ZERO;
      irq_oe_n_ff <= 1'b1;
      irq_lvl_ff <= 1'b0;
    end else begin
      cst_ff <= nxt_cst;
      status_ff <= nxt_status;
      mask_ff <= nxt_mask;
      rdata_ff <= nxt_rdata;
      irq_oe_n_ff <= nxt_irq_oe_n;
      irq_lvl_ff <= 1'b0;
    end
  end

  // general purpose registers reached over the link
  msp_reg_mem u_mem (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .we_i(mem_we),
    .waddr_i(req_ff.addr),
    .wdata_i(req_ff.data),
    .raddr_i(req_ff.addr),
    .rdata_o(mem_rdata)
  );

  // pins straight from flops
  assign miso_o = miso_ff;
  assign miso_oe_n_o = miso_oe_n_ff;
  assign irq_o = irq_lvl_ff;
  assign irq_oe_n_o = irq_oe_n_ff;

endmodule : msp_serial_port
`default_nettype wire

// >>> sim/msp_serial_port_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module msp_serial_port_monitor (
  // clocks and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic link_sclk_i,
  // serial pins
  input wire logic cs_n_i,
  input wire logic miso_o,
  input wire logic miso_oe_n_o,
  // interrupt pin and event sources
  input wire logic irq_o,
  input wire logic irq_oe_n_o,
  input wire logic act_half_i,
  input wire logic app_half_i,
  input wire logic wave_rdy_i
);
  logic ev; // any event source high
  logic [3:0] quiet_ff; // core cycles with select high, saturating
  logic [3:0] nxt_quiet;
  logic [4:0] rise_ff; // rising sclk edges in this frame, saturating
  logic [4:0] nxt_rise;
  logic miso_fall_ff; // data pin value at the last falling sclk edge
  assign ev = act_half_i | app_half_i | wave_rdy_i;
  // next values of the helper counters
  always_comb begin
    nxt_quiet = (quiet_ff == 4'hF) ? quiet_ff : quiet_ff + 4'h1;
    if (!cs_n_i) begin
      nxt_quiet = 4'h0;
    end
    nxt_rise = (rise_ff == 5'h1F) ? rise_ff : rise_ff + 5'h01;
  end
  // quiet counter in the core domain
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) quiet_ff <= 4'h0;
    else quiet_ff <= nxt_quiet;
  end
  // edge counter in the link domain, cleared while deselected
  always_ff @(posedge link_sclk_i or posedge cs_n_i) begin
    if (cs_n_i) rise_ff <= 5'h00;
    else rise_ff <= nxt_rise;
  end
  // data pin seen at falling edges
  always_ff @(negedge link_sclk_i) begin
    miso_fall_ff <= miso_o;
  end
  sequence s_idle_pins;
    (miso_oe_n_o && irq_oe_n_o) [*2];
  endsequence
  property p_rst_hold;
    @(posedge core_clk_i) !rst_n_i |-> miso_oe_n_o && irq_oe_n_o && !miso_o;
  endproperty
  property p_rst_rel;
    @(posedge core_clk_i) disable iff (!rst_n_i) $rose(rst_n_i) |-> s_idle_pins;
  endproperty
  property p_irq_level;
    @(posedge core_clk_i) disable iff (!rst_n_i) !irq_o;
  endproperty
  property p_irq_quiet;
    @(posedge core_clk_i) disable iff (!rst_n_i)
      quiet_ff >= 4'h8 && !$past(ev) && !$past(ev, 2) |-> $stable(irq_oe_n_o);
  endproperty
  property p_cs_release;
    @(posedge core_clk_i) disable iff (!rst_n_i) cs_n_i |-> miso_oe_n_o;
  endproperty
  property p_oe_window;
    @(posedge link_sclk_i) disable iff (!rst_n_i || cs_n_i) rise_ff <= 5'h10 |-> miso_oe_n_o;
  endproperty
  property p_launch;
    @(posedge link_sclk_i) disable iff (!rst_n_i || cs_n_i)
      !miso_oe_n_o |-> miso_o == miso_fall_ff;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("pins not idle in reset");
  a_rst_rel: assert property (p_rst_rel) else $error("pins not idle after reset");
  a_irq_level: assert property (p_irq_level) else $error("irq data not low");
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq moved without cause");
  a_cs_release: assert property (p_cs_release) else $error("data driven unselected");
  a_oe_window: assert property (p_oe_window) else $error("data driven too early");
  a_launch: assert property (p_launch) else $error("data changed on falling edge");
endmodule : msp_serial_port_monitor
bind msp_serial_port msp_serial_port_monitor u_mon (.core_clk_i, .rst_n_i, .link_sclk_i,
  .cs_n_i, .miso_o, .miso_oe_n_o, .irq_o, .irq_oe_n_o, .act_half_i, .app_half_i, .wave_rdy_i);
`default_nettype wire

// >>> sim/msp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module msp_host_model (
  // serial pins toward the device
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  // clock stands low and select high outside frames; a short select at power-up lets the
  // falling device reset reach the frame flops as a real edge instead of a time-zero race
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b0;
    mosi_o = 1'b0;
    #2 cs_n_o = 1'b1;
  end
  // select or deselect, with margin on both sides
  task automatic sel(input logic on);
    #20;
    cs_n_o = !on;
    if (!on) mosi_o = !mosi_o;
    #20;
  endtask : sel
  // one byte msb first on a 15 ns clock
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      #2 mosi_o = tx[i];
      #5.5 sclk_o = 1'b1;
      #7.5 rx[i] = miso_i;
      sclk_o = 1'b0;
    end
    #60;
  endtask : xfer
endmodule : msp_host_model
`default_nettype wire

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "msp_cfg.svh"
module tb_top;
  logic core_clk_i; // core clock
  logic rst_n_i; // reset, active low
  logic sclk, cs_n, mosi; // serial pins from the host
  logic miso_o, miso_oe_n_o, irq_o, irq_oe_n_o; // device pins
  logic [2:0] ev_vec; // event pulses
  wire miso_pin = miso_oe_n_o ? 1'bz : miso_o; // no pull on data
  wire irq_pin = irq_oe_n_o ? 1'b1 : irq_o; // pulled up
  int miscompares, checks, cyc;
  msp_serial_port u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .link_sclk_i(sclk),
    .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso_o), .miso_oe_n_o(miso_oe_n_o), .irq_o(irq_o),
    .irq_oe_n_o(irq_oe_n_o), .act_half_i(ev_vec[0]), .app_half_i(ev_vec[1]),
    .wave_rdy_i(ev_vec[2]));
  msp_host_model u_host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso_pin));
  // core clock
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = !core_clk_i;
  end
  // compare and count
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // write one register
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] rx;
    u_host.sel(1'b1);
    u_host.xfer({1'b1, 3'h0, a}, rx);
    u_host.xfer(d, rx);
    u_host.sel(1'b0);
  endtask : wr
  // read one register twice in one frame
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] rx;
    u_host.sel(1'b1);
    u_host.xfer({4'h0, a}, rx);
    u_host.xfer(8'h00, rx);
    check("oe_turn", {7'h00, miso_oe_n_o}, 8'h01);
    u_host.xfer(8'h00, rx);
    check("rdata", rx, exp);
    u_host.xfer(8'h00, rx);
    check("rdata_rep", rx, exp);
    u_host.sel(1'b0);
    check("oe_desel", {7'h00, miso_oe_n_o}, 8'h01);
  endtask : rd
  // one-cycle event pulse
  task automatic pulse(input logic [2:0] v);
    @(posedge core_clk_i);
    #1 ev_vec = v;
    @(posedge core_clk_i);
    #1 ev_vec = 3'h0;
    repeat (4) @(posedge core_clk_i);
  endtask : pulse
  task automatic t_regs;
    wr(4'h5, 8'hA5);
    wr(4'h6, 8'h3C);
    rd(4'h5, 8'hA5);
    rd(4'h6, 8'h3C);
    $display("test regs done");
  endtask : t_regs
  task automatic t_events;
    logic [7:0] b;
    for (int s = 0; s < 3; s++) begin
      b = 8'h01 << s;
      pulse(b[2:0]);
      check("irq_masked", {7'h00, irq_pin}, 8'h01);
      rd(`MSP_ADDR_STATUS, b);
      wr(`MSP_ADDR_MASK, b);
      check("irq_low", {7'h00, irq_pin}, 8'h00);
      wr(`MSP_ADDR_STATUS, b);
      check("irq_clear", {7'h00, irq_pin}, 8'h01);
      wr(`MSP_ADDR_MASK, 8'h00);
    end
    $display("test events done");
  endtask : t_events
  task automatic t_reset2;
    wr(`MSP_ADDR_MASK, 8'h07);
    pulse(3'h4);
    check("irq_set", {7'h00, irq_pin}, 8'h00);
    #1 rst_n_i = 1'b0;
    #20 check("irq_rst", {7'h00, irq_pin}, 8'h01);
    check("oe_rst", {7'h00, miso_oe_n_o}, 8'h01);
    @(posedge core_clk_i);
    #1 rst_n_i = 1'b1;
    repeat (3) @(posedge core_clk_i);
    rd(`MSP_ADDR_MASK, 8'h00);
    rd(`MSP_ADDR_STATUS, 8'h00);
    $display("test reset done");
  endtask : t_reset2
  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // hang guard
  always @(posedge core_clk_i) begin
    cyc++;
    // the tests need about 1400 core cycles; the ceiling leaves a wide margin
    if (cyc == 6000) begin
      miscompares++;
      tally_and_finish;
    end
  end
  // main sequence
  initial begin
    // start high and drop at once, so every asynchronous reset sees a real edge
    rst_n_i = 1'b1;
    ev_vec = 3'h0;
    #1 rst_n_i = 1'b0;
    repeat (8) @(posedge core_clk_i);
    #1 rst_n_i = 1'b1;
    repeat (3) @(posedge core_clk_i);
    check("irq_idle", {7'h00, irq_pin}, 8'h01);
    t_regs;
    t_events;
    t_reset2;
    tally_and_finish;
  end
endmodule : tb_top
`default_nettype wire
